// [sdsf_pkg.sv]
package sdsf_pkg;
	// Instruction codes honoured by every die, active or idle
	localparam logic [7:0] OP_DIE_SELECT = 8'hC2;
	localparam logic [7:0] OP_DEVICE_RESET = 8'hFF;
	// Identifier of the die that is active after power-up or device reset
	localparam logic [7:0] DIE_ZERO = 8'h00;
	// Byte shifted out when the read side has nothing ready
	localparam logic [7:0] TX_FILL = 8'hFF;
	// Lane usage as signalled by the instruction decoder
	localparam logic [1:0] LANE_SINGLE = 2'h0;
	localparam logic [1:0] LANE_DUAL = 2'h1;
	localparam logic [1:0] LANE_QUAD = 2'h2;
	// Register lock setting under which the protect pin guards the array region
	localparam logic [1:0] LOCK_HW = 2'h1;
	// Reset values
	localparam logic ARMED_RESET = 1'h0;
	localparam logic [2:0] CNT_RESET = 3'h0;
	localparam logic [3:0] OE_RESET = 4'h0;
	// Receive buffer shape
	localparam int RX_FIFO_DEPTH = 8;
	localparam int RX_FIFO_WIDTH = 9;

	typedef enum logic [1:0] {ST_OPCODE, ST_DIE_IDENTIFIER, ST_BODY, ST_IGNORE} sdsf_state_e;

	// Clock edge index of the last edge of a byte
	function automatic logic [2:0] last_edge(input logic [1:0] mode);
		case (mode)
			LANE_DUAL: last_edge = 3'h3;
			LANE_QUAD: last_edge = 3'h1;
			default: last_edge = 3'h7;
		endcase
	endfunction

	// Shift a byte by one edge's worth of lanes, MSB first
	function automatic logic [7:0] shift_lanes(input logic [7:0] s, input logic [3:0] in, input logic [1:0] mode);
		case (mode)
			LANE_DUAL: shift_lanes = {s[5:0], in[1:0]};
			LANE_QUAD: shift_lanes = {s[3:0], in[3:0]};
			default: shift_lanes = {s[6:0], in[0]};
		endcase
	endfunction
endpackage

// [sdsf_stream_if.sv]
interface sdsf_stream_if #(parameter int WIDTH = 9) ();
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// [sdsf_fifo.sv]
module sdsf_fifo
	import sdsf_pkg::*;
	#(parameter int WIDTH = RX_FIFO_WIDTH,
	parameter int DEPTH = RX_FIFO_DEPTH)
	(input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	sdsf_stream_if.snk wr, // Fill side
	sdsf_stream_if.src rd); // Drain side

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;

	wire do_wr = wr.valid & wr.ready;
	wire do_rd = rd.valid & rd.ready;

	assign wr.ready = count != CNT_FULL;
	assign rd.valid = count != '0;
	assign rd.data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr] <= wr.data;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : PW'(wr_ptr + 1'b1);
			if (do_rd)
				rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : PW'(rd_ptr + 1'b1);
			if (do_wr != do_rd)
				count <= do_wr ? CW'(count + 1'b1) : CW'(count - 1'b1);
		end
	end
endmodule // sdsf_fifo

// [sdsf_pin_edges.sv]
module sdsf_pin_edges (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic sclk, // Serial clock pin level
	input wire logic cs_n, // Chip select pin, active low
	input wire logic hold_n, // Pause pin level, active low
	input wire logic quad_active, // Lane three carries data
	output logic sclk_rise, // Rising edge, usable
	output logic sclk_fall, // Falling edge, usable
	output logic cs_fall, // Chip select asserted
	output logic cs_rise, // Chip select released
	output logic paused // Pause condition in force
);
	logic sclk_q;
	logic cs_q;

	assign sclk_rise = sclk & ~sclk_q & ~cs_n & ~paused;
	assign sclk_fall = ~sclk & sclk_q & ~cs_n & ~paused;
	assign cs_fall = ~cs_n & cs_q;
	assign cs_rise = cs_n & ~cs_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'h0;
			// Low, so a chip select held low through reset never arms
			cs_q <= 1'h0;
			paused <= 1'h0;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			// Pause follows the pin only while the clock is low, so a pause never cuts a bit
			if (cs_n || quad_active)
				paused <= 1'h0;
			else if (!sclk)
				paused <= ~hold_n;
		end
	end
endmodule // sdsf_pin_edges

// [sdsf_front_end.sv]
//
// Contract
// - Every die takes die select plus identifier
// - Every die takes device reset, returns to power-up
// - Die zero active after power-up and reset
// - One die active; idle die never drives
// - Chip select high: deselected, lanes released
// - Ignore instructions until first chip select fall
// - Single lane: sample rising, shift out falling
// - Dual/quad: sample rising, drive falling
// - Single/dual lanes 0-1; quad 0-3
// - Select bit 0: pin with lock bits guards protection register
// - Select bit 1: low pin refuses all writes
// - Select bit 1 refuses quad reads
// - Pin with lock bits guards array region
// - Low pause pin: output off, inputs ignored
// - Quad read/load: pause pin is lane three
// - Idle die ignores other instructions
// - Clock idle low or high both work
module sdsf_front_end
	import sdsf_pkg::*;
	#(parameter logic [7:0] DIE_IDENTIFIER = DIE_ZERO, // Fixed identifier of this die
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH)
	(input wire logic clk, // System clock, 20 MHz
	input wire logic rstn, // Async reset, active low
	input wire logic cs_n, // Chip select pin
	input wire logic sclk, // Serial clock pin
	input wire logic [3:0] lane_in, // Data lane levels seen at the pins
	output logic [3:0] lane_out, // Data lane drive values
	output logic [3:0] lane_oe, // Data lane drive enables
	input wire logic [1:0] lane_mode, // Lane usage of current phase
	input wire logic drive_req, // Current phase sends data to host
	input wire logic quad_read, // Quad read instruction under way
	input wire logic quad_load, // Quad buffer-load instruction under way
	input wire logic wp_sel, // Hardware-protect select bit
	input wire logic [3:0] block_protect_field, // Block protect bits
	input wire logic [1:0] register_lock_field, // Register lock bits
	input wire logic [7:0] tx_data, // Byte to send to host
	input wire logic tx_valid, // Byte to send is present
	output logic tx_ready, // Byte to send taken
	output logic [7:0] rx_data, // Received byte
	output logic rx_first, // Received byte is an opcode
	output logic rx_valid, // Received byte present
	input wire logic rx_ready, // Received byte taken
	output logic rx_overrun, // Byte lost to a full buffer
	output logic die_active, // This die owns the bus
	output logic device_reset, // Device reset instruction seen
	output logic selected, // Chip select low and armed
	output logic paused, // Pause condition in force
	output logic quad_refused, // Quad read refused
	output logic all_write_blocked, // Every write refused
	output logic protreg_write_blocked, // Protection register writes refused
	output logic region_write_locked // Protected array region locked by pin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sdsf_stream_if #(.WIDTH(RX_FIFO_WIDTH)) fifo_in ();
	sdsf_stream_if #(.WIDTH(RX_FIFO_WIDTH)) fifo_out ();

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic pause_now;
	logic armed;
	sdsf_state_e state;
	sdsf_state_e next_state;
	logic [7:0] rx_shift;
	logic [2:0] rx_cnt;
	logic [7:0] tx_shift;
	logic [2:0] tx_cnt;

	// Lane roles
	wire hold_n_pin = lane_in[3];
	wire wp_n_pin = lane_in[2];
	wire quad_refused_now = wp_sel & quad_read;
	wire quad_active = ~cs_n & ((quad_read & ~wp_sel) | quad_load);
	wire wp_low = ~wp_n_pin & ~quad_active;

	sdsf_pin_edges u_edges (
		.clk(clk),
		.rstn(rstn),
		.sclk(sclk),
		.cs_n(cs_n),
		.hold_n(hold_n_pin),
		.quad_active(quad_active),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall),
		.cs_fall(cs_fall),
		.cs_rise(cs_rise),
		.paused(pause_now)
	);

	// Receive side: host bits sampled on rising edges
	wire take_in = armed & sclk_rise & ~drive_req;
	wire [7:0] rx_next = shift_lanes(rx_shift, lane_in, lane_mode);
	wire byte_done = take_in & (rx_cnt == last_edge(lane_mode));
	wire is_opcode = state == ST_OPCODE;
	wire op_select = byte_done & is_opcode & (rx_next == OP_DIE_SELECT);
	wire op_reset = byte_done & is_opcode & (rx_next == OP_DEVICE_RESET);
	wire id_done = byte_done & (state == ST_DIE_IDENTIFIER);
	wire id_match = rx_next == DIE_IDENTIFIER;
	wire plain_op = is_opcode & ~op_select & ~op_reset;
	// Idle die forwards nothing
	wire rx_push = byte_done & die_active & (plain_op | (state == ST_BODY));
	wire rx_drop = rx_push & ~fifo_in.ready;

	assign fifo_in.data = {plain_op, rx_next};
	assign fifo_in.valid = rx_push;

	// Transmit side: device bits driven on falling edges
	wire may_drive = armed & ~cs_n & ~pause_now & die_active & drive_req & ~quad_refused_now;
	wire take_out = may_drive & sclk_fall;
	wire tx_load = take_out & (tx_cnt == CNT_RESET);
	wire [7:0] tx_src = tx_load ? (tx_valid ? tx_data : TX_FILL) : tx_shift;
	wire [2:0] tx_last = last_edge(lane_mode);

	// Single uses the output lane only; dual lanes 0-1; quad all four
	wire [3:0] lane_bits = (lane_mode == LANE_QUAD) ? tx_src[7:4] :
		(lane_mode == LANE_DUAL) ? {2'h0, tx_src[7:6]} : {2'h0, tx_src[7], 1'h0};
	wire [3:0] lane_en = (lane_mode == LANE_QUAD) ? 4'hF :
		(lane_mode == LANE_DUAL) ? 4'h3 : 4'h2;
	wire [3:0] next_oe = may_drive ? lane_en : OE_RESET;

	// Protection
	wire next_all_blocked = wp_sel & wp_low;
	wire next_protreg_blocked = wp_low & (wp_sel | (register_lock_field == LOCK_HW));
	wire next_region_locked = wp_low & (register_lock_field == LOCK_HW) & (block_protect_field != 4'h0);

	always_comb begin
		next_state = state;
		if (cs_rise) begin
			next_state = ST_OPCODE;
		end else if (byte_done) begin
			case (state)
				ST_OPCODE: begin
					if (op_select)
						next_state = ST_DIE_IDENTIFIER;
					else if (op_reset || !die_active)
						next_state = ST_IGNORE;
					else
						next_state = ST_BODY;
				end
				ST_DIE_IDENTIFIER: next_state = ST_IGNORE;
				ST_BODY: next_state = ST_BODY;
				ST_IGNORE: next_state = ST_IGNORE;
				default: next_state = ST_OPCODE;
			endcase
		end
	end

	// Power-up arming and die ownership
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			armed <= ARMED_RESET;
			die_active <= (DIE_IDENTIFIER == DIE_ZERO);
			device_reset <= 1'h0;
		end else begin
			if (cs_fall)
				armed <= 1'h1;
			if (op_reset)
				die_active <= (DIE_IDENTIFIER == DIE_ZERO);
			else if (id_done)
				die_active <= id_match;
			device_reset <= op_reset;
		end
	end

	// Serial state; a new frame always restarts at the opcode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_OPCODE;
			rx_shift <= 8'h00;
			rx_cnt <= CNT_RESET;
			tx_shift <= 8'h00;
			tx_cnt <= CNT_RESET;
		end else begin
			state <= next_state;
			if (cs_rise || cs_fall) begin
				rx_cnt <= CNT_RESET;
				tx_cnt <= CNT_RESET;
			end else begin
				if (take_in) begin
					rx_shift <= rx_next;
					rx_cnt <= byte_done ? CNT_RESET : 3'(rx_cnt + 3'h1);
				end
				if (take_out) begin
					tx_shift <= shift_lanes(tx_src, 4'h0, lane_mode);
					tx_cnt <= (tx_cnt == tx_last) ? CNT_RESET : 3'(tx_cnt + 3'h1);
				end
			end
		end
	end

	// Pin and status outputs, all registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lane_out <= 4'h0;
			lane_oe <= OE_RESET;
			tx_ready <= 1'h0;
			selected <= 1'h0;
			paused <= 1'h0;
			quad_refused <= 1'h0;
			all_write_blocked <= 1'h0;
			protreg_write_blocked <= 1'h0;
			region_write_locked <= 1'h0;
			rx_overrun <= 1'h0;
		end else begin
			if (take_out)
				lane_out <= lane_bits;
			lane_oe <= next_oe;
			tx_ready <= tx_load & tx_valid;
			selected <= armed & ~cs_n;
			paused <= pause_now;
			quad_refused <= quad_refused_now;
			all_write_blocked <= next_all_blocked;
			protreg_write_blocked <= next_protreg_blocked;
			region_write_locked <= next_region_locked;
			// Loss wins over the clear at a new frame
			rx_overrun <= rx_drop | (rx_overrun & ~cs_fall);
		end
	end

	// Host cannot be stalled, so a full buffer drops the byte and flags it
	sdsf_fifo #(.WIDTH(RX_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rstn(rstn),
		.wr(fifo_in.snk),
		.rd(fifo_out.src)
	);

	assign rx_data = fifo_out.data[7:0];
	assign rx_first = fifo_out.data[8];
	assign rx_valid = fifo_out.valid;
	assign fifo_out.ready = rx_ready;

	sequence s_id_byte;
		id_done;
	endsequence

	sequence s_reset_byte;
		op_reset;
	endsequence

	property p_die_select;
		s_id_byte |=> (die_active == ($past(id_match)));
	endproperty
	a_die_select: assert property (p_die_select) else $error("die select result wrong");

	property p_device_reset;
		s_reset_byte |=> device_reset && (die_active == (DIE_IDENTIFIER == DIE_ZERO)) && (state == ST_IGNORE);
	endproperty
	a_device_reset: assert property (p_device_reset) else $error("device reset not applied");

	property p_idle_silent;
		!die_active |=> (lane_oe == 4'h0);
	endproperty
	a_idle_silent: assert property (p_idle_silent) else $error("idle die drives lanes");

	property p_deselect_release;
		cs_n |=> (lane_oe == 4'h0) ##1 (lane_oe == 4'h0) || !cs_n;
	endproperty
	a_deselect_release: assert property (p_deselect_release) else $error("lanes driven while deselected");

	property p_unarmed_ignore;
		!armed |-> !rx_push && !take_out;
	endproperty
	a_unarmed_ignore: assert property (p_unarmed_ignore) else $error("instruction taken before arming");

	property p_single_out;
		(take_out && lane_mode == LANE_SINGLE) |=> (lane_out[1] == $past(tx_src[7])) && (lane_oe[0] == 1'h0);
	endproperty
	a_single_out: assert property (p_single_out) else $error("single lane bit wrong");

	property p_dual_out;
		(take_out && lane_mode == LANE_DUAL) |=> (lane_out[1:0] == $past(tx_src[7:6])) && (lane_oe[3:2] == 2'h0);
	endproperty
	a_dual_out: assert property (p_dual_out) else $error("dual lane bits wrong");

	property p_pause_quiet;
		pause_now |=> (lane_oe == 4'h0) && !$past(take_in);
	endproperty
	a_pause_quiet: assert property (p_pause_quiet) else $error("activity during pause");

	property p_quad_no_pause;
		quad_active && $past(quad_active) |-> !pause_now;
	endproperty
	a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause during quad operation");

	property p_hw_protect;
		(wp_sel && !wp_n_pin && !quad_active) |=> all_write_blocked && protreg_write_blocked;
	endproperty
	a_hw_protect: assert property (p_hw_protect) else $error("hardware protection missing");

	property p_quad_refuse;
		(wp_sel && quad_read) |=> quad_refused && (lane_oe == 4'h0);
	endproperty
	a_quad_refuse: assert property (p_quad_refuse) else $error("quad read not refused");

	property p_idle_ignore;
		(state == ST_IGNORE) |-> !rx_push;
	endproperty
	a_idle_ignore: assert property (p_idle_ignore) else $error("ignored instruction forwarded");

	property p_soft_protect;
		(!wp_sel && !wp_n_pin && !quad_active && register_lock_field == LOCK_HW) |=> protreg_write_blocked && !all_write_blocked;
	endproperty
	a_soft_protect: assert property (p_soft_protect) else $error("software protection wrong");

	property p_tx_taken;
		(tx_load && tx_valid) |=> tx_ready;
	endproperty
	a_tx_taken: assert property (p_tx_taken) else $error("send byte not acknowledged");

	property p_selected_off;
		(cs_n || !armed) |=> !selected;
	endproperty
	a_selected_off: assert property (p_selected_off) else $error("selected while released or unarmed");

	property p_quad_out;
		(take_out && lane_mode == LANE_QUAD) |=> (lane_out == $past(tx_src[7:4])) && (lane_oe == 4'hF);
	endproperty
	a_quad_out: assert property (p_quad_out) else $error("quad lane bits wrong");

	property p_region_lock;
		(wp_low && register_lock_field == LOCK_HW && block_protect_field != 4'h0) |=> region_write_locked;
	endproperty
	a_region_lock: assert property (p_region_lock) else $error("array region not locked");

	sequence s_frame_end;
		cs_rise;
	endsequence

	property p_frame_restart;
		s_frame_end |=> (state == ST_OPCODE) && (rx_cnt == CNT_RESET);
	endproperty
	a_frame_restart: assert property (p_frame_restart) else $error("frame did not restart");

	property p_idle_opcode;
		(byte_done && is_opcode && !die_active && !op_select) |=> (state == ST_IGNORE);
	endproperty
	a_idle_opcode: assert property (p_idle_opcode) else $error("idle die took an instruction");
endmodule // sdsf_front_end

// [sdsf_host_model.sv]
module sdsf_host_model (
	input wire logic clk, // System clock
	input wire logic [3:0] dev_out, // Device lane values
	input wire logic [3:0] dev_oe, // Device lane enables
	output logic cs_n, // Chip select
	output logic sclk, // Serial clock, idle low
	output logic [3:0] lane_w // Resolved lane levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] drv;
	logic [3:0] drv_oe;
	logic wp_lvl;
	logic hold_lvl;
	logic noise;
	initial begin
		cs_n = 1'b0;
		sclk = 1'b0;
		drv = 4'h0;
		drv_oe = 4'h0;
		wp_lvl = 1'b1;
		hold_lvl = 1'b1;
		noise = 1'b0;
	end
	always @(posedge clk) begin
		noise <= ~noise;
	end
	// Released lanes 0-1 toggle so a stale bit never passes for data; lanes 2-3 rest at their pin levels
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_w[i] = dev_oe[i] ? dev_out[i] : (drv_oe[i] ? drv[i] : (i == 2 ? wp_lvl : (i == 3 ? hold_lvl : noise)));
		end
	end
	task automatic frame_start();
		@(posedge clk) cs_n <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic frame_end();
		@(posedge clk) begin
			sclk <= 1'b0;
			drv_oe <= 4'h0;
		end
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// Bits change at falls and are read at rises; phases are long to cover pin sync delay
	task automatic xfer(input logic [7:0] b, input logic [1:0] m, output logic [7:0] r);
		logic [7:0] s;
		int n;
		s = b;
		r = 8'h00;
		n = (m == 2'h2) ? 2 : ((m == 2'h1) ? 4 : 8);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			sclk <= 1'b0;
			drv_oe <= (m == 2'h2) ? 4'hF : ((m == 2'h1) ? 4'h3 : 4'h1);
			drv <= (m == 2'h2) ? s[7:4] : ((m == 2'h1) ? {2'h0, s[7:6]} : {3'h0, s[7]});
			s = (m == 2'h2) ? {s[3:0], 4'h0} : ((m == 2'h1) ? {s[5:0], 2'h0} : {s[6:0], 1'b0});
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			r = {r[6:0], lane_w[1]};
			repeat (2) @(posedge clk);
		end
	endtask
endmodule // sdsf_host_model

// [test_stacked_die_spi_front_end.sv]
module test_stacked_die_spi_front_end
	import sdsf_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, drive_req, quad_read, quad_load, wp_sel, tx_valid, rx_ready, tx_ready;
	logic [1:0] lane_mode;
	logic [3:0] bpf;
	logic [1:0] rlf;
	logic [7:0] tx_data, rx_data, b, r;
	logic [3:0] lane_out, lane_oe;
	logic rx_first, rx_valid, rx_overrun, die_active, device_reset, paused, quad_refused;
	logic all_write_blocked, protreg_write_blocked, region_write_locked;
	logic watch, rst_seen, oe_any, selected;
	logic [3:0] taken;
	logic [31:0] rnd;
	logic [8:0] expq[$];
	int fails, tests_run;
	wire cs_n, sclk;
	wire [3:0] lane_w;
	sdsf_front_end #(.DIE_IDENTIFIER(8'h00)) i_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .lane_in(lane_w),
		.lane_out(lane_out), .lane_oe(lane_oe), .lane_mode(lane_mode), .drive_req(drive_req), .quad_read(quad_read),
		.quad_load(quad_load), .wp_sel(wp_sel), .block_protect_field(bpf), .register_lock_field(rlf), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_overrun(rx_overrun), .die_active(die_active), .device_reset(device_reset),
		.selected(selected),
		.paused(paused), .quad_refused(quad_refused), .all_write_blocked(all_write_blocked),
		.protreg_write_blocked(protreg_write_blocked), .region_write_locked(region_write_locked));
	sdsf_host_model i_host (.clk(clk), .dev_out(lane_out), .dev_oe(lane_oe), .cs_n(cs_n), .sclk(sclk), .lane_w(lane_w));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic next_byte();
		rnd = lfsr(rnd);
		b = rnd[7:0];
		if (b == OP_DIE_SELECT || b == OP_DEVICE_RESET) b = b ^ 8'h01;
	endtask
	task automatic send(input logic [7:0] v, input logic [1:0] m, input logic first, input logic keep);
		if (keep) expq.push_back({first, v});
		lane_mode <= m;
		i_host.xfer(v, m, r);
	endtask
	task automatic wait_drain();
		for (int i = 0; i < 400 && expq.size() != 0; i++) @(posedge clk);
		@(posedge clk);
		if (expq.size() != 0) begin
			fails++;
			finish_test();
		end
	endtask
	// Any received byte taken while watch is set with no note waiting is flagged
	always @(posedge clk) begin
		if (lane_oe !== 4'h0) oe_any <= 1'b1;
		if (device_reset === 1'b1) rst_seen <= 1'b1;
		if (tx_ready === 1'b1) taken <= taken + 4'h1;
		if (rstn && watch && rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (expq.size() == 0) check({rx_first, rx_data}, 9'hXX);
			else check({rx_first, rx_data}, expq.pop_front());
		end
	end
	initial begin
		rstn = 1'b0; rnd = 32'h7AA5; drive_req = 1'b0; quad_read = 1'b0; quad_load = 1'b0; wp_sel = 1'b0;
		bpf = 4'h0; rlf = 2'h0; tx_data = 8'h00; tx_valid = 1'b0; rx_ready = 1'b1; lane_mode = LANE_SINGLE;
		watch = 1'b1; rst_seen = 1'b0; oe_any = 1'b0; fails = 0; tests_run = 0;
		taken = 4'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		check(9'(die_active), 9'h001);
		check(9'(selected), 9'h000);
		check(9'(lane_oe), 9'h000);
		send(8'h5A, LANE_SINGLE, 1'b0, 1'b0);
		i_host.frame_end();
		i_host.frame_start();
		next_byte(); send(b, LANE_SINGLE, 1'b1, 1'b1);
		next_byte(); send(b, LANE_DUAL, 1'b0, 1'b1);
		i_host.frame_end();
		i_host.frame_start();
		next_byte(); send(b, LANE_SINGLE, 1'b1, 1'b1);
		quad_load <= 1'b1;
		next_byte(); send(b, LANE_QUAD, 1'b0, 1'b1);
		i_host.frame_end();
		quad_load <= 1'b0;
		wait_drain();
		i_host.frame_start();
		next_byte(); send(b, LANE_SINGLE, 1'b1, 1'b1);
		next_byte(); tx_data <= b; tx_valid <= 1'b1; drive_req <= 1'b1;
		i_host.xfer(8'h00, LANE_SINGLE, r);
		check(9'(r), 9'(b));
		check(9'(lane_oe), 9'h002);
		check(9'(taken), 9'h001);
		check(9'(selected), 9'h001);
		drive_req <= 1'b0; tx_valid <= 1'b0;
		i_host.frame_end();
		check(9'(lane_oe), 9'h000);
		check(9'(selected), 9'h000);
		wait_drain();
		rx_ready <= 1'b0;
		i_host.frame_start();
		for (int i = 0; i < 9; i++) begin
			next_byte(); send(b, LANE_SINGLE, i == 0, i < 8);
		end
		i_host.frame_end();
		check(9'(rx_overrun), 9'h001);
		rx_ready <= 1'b1;
		wait_drain();
		check(9'(rx_valid), 9'h000);
		i_host.frame_start();
		check(9'(rx_overrun), 9'h000);
		i_host.hold_lvl <= 1'b0;
		repeat (3) @(posedge clk);
		check(9'(paused), 9'h001);
		send(8'h3C, LANE_SINGLE, 1'b1, 1'b0);
		i_host.hold_lvl <= 1'b1;
		i_host.sclk <= 1'b0;
		repeat (3) @(posedge clk);
		check(9'(paused), 9'h000);
		quad_load <= 1'b1; i_host.hold_lvl <= 1'b0;
		repeat (3) @(posedge clk);
		check(9'(paused), 9'h000);
		quad_load <= 1'b0; i_host.hold_lvl <= 1'b1;
		i_host.frame_end();
		i_host.frame_start();
		for (int i = 0; i < 32; i++) begin
			wp_sel <= i[0]; i_host.wp_lvl <= i[1]; rlf <= i[3:2]; bpf <= i[4] ? 4'h5 : 4'h0;
			repeat (3) @(posedge clk);
			check(9'(all_write_blocked), 9'(i[0] & ~i[1]));
			check(9'(protreg_write_blocked), 9'(~i[1] & (i[0] | (i[3:2] == LOCK_HW))));
			if (!i[0]) check(9'(region_write_locked), 9'(~i[1] & (i[3:2] == LOCK_HW) & i[4]));
		end
		wp_sel <= 1'b1; quad_read <= 1'b1;
		repeat (3) @(posedge clk);
		check(9'(quad_refused), 9'h001);
		wp_sel <= 1'b0; i_host.wp_lvl <= 1'b0; rlf <= LOCK_HW;
		repeat (3) @(posedge clk);
		check(9'(quad_refused), 9'h000);
		check(9'(protreg_write_blocked), 9'h000);
		quad_read <= 1'b0; i_host.wp_lvl <= 1'b1; rlf <= 2'h0;
		i_host.frame_end();
		watch <= 1'b0;
		i_host.frame_start();
		send(OP_DIE_SELECT, LANE_SINGLE, 1'b1, 1'b0);
		send(8'h01, LANE_SINGLE, 1'b0, 1'b0);
		i_host.frame_end();
		watch <= 1'b1;
		check(9'(die_active), 9'h000);
		i_host.frame_start();
		next_byte(); send(b, LANE_SINGLE, 1'b1, 1'b0);
		oe_any <= 1'b0; tx_valid <= 1'b1; drive_req <= 1'b1;
		i_host.xfer(8'h00, LANE_SINGLE, r);
		drive_req <= 1'b0; tx_valid <= 1'b0;
		i_host.frame_end();
		check(9'(oe_any), 9'h000);
		check(9'(taken), 9'h001);
		watch <= 1'b0;
		i_host.frame_start();
		send(OP_DEVICE_RESET, LANE_SINGLE, 1'b1, 1'b0);
		i_host.frame_end();
		watch <= 1'b1;
		check(9'(rst_seen), 9'h001);
		check(9'(die_active), 9'h001);
		i_host.sclk <= 1'b1;
		i_host.frame_start();
		next_byte(); send(b, LANE_SINGLE, 1'b1, 1'b1);
		i_host.frame_end();
		wait_drain();
		finish_test();
	end
endmodule // test_stacked_die_spi_front_end
